//--- src/wch_params.svh
// Constants for the weld cycle handshake: register offsets, fields, counts.
`ifndef WCH_PARAMS_SVH
`define WCH_PARAMS_SVH
// Register offsets of the controller end (byte addresses).
`define WCH_CTRL_OFS 8'h00
`define WCH_STAT_OFS 8'h04
`define WCH_IRQ_OFS 8'h08
`define WCH_MASK_OFS 8'h0c
// Control register fields of the controller end.
`define WCH_CTRL_START 0
`define WCH_CTRL_ABORT 1
`define WCH_CTRL_ESTOP 2
`define WCH_CTRL_AUTORST 3
`define WCH_CTRL_SINGLE 4
// Interrupt status fields of the controller end.
`define WCH_IRQ_FAULT 0
`define WCH_IRQ_PERMIT 1
`define WCH_IRQ_CLEAR 2
`define WCH_IRQ_READY 3
`define WCH_IRQ_W 4
// Debounce length in clock cycles for every discrete input.
`define WCH_DEB_CYC 4
// Weld, retract, clearance and hardware check times in clock cycles.
`define WCH_WELD_CYC 16
`define WCH_RETRACT_CYC 16
`define WCH_CLEAR_CYC 8
`define WCH_CHECK_CYC 64
// Length of the controller's reset pulse; it must outlast the welder's
// two synchroniser flops plus its debounce time.
`define WCH_RST_PULSE_CYC 8
`endif

//--- src/wch_pkg.sv
// Types used by the welder end of the weld cycle handshake.
package wch_pkg;
    // Device states.
    typedef enum logic [2:0] {
        WCH_INIT = 3'b000,
        WCH_READY = 3'b001,
        WCH_WELD = 3'b010,
        WCH_RETRACT = 3'b011,
        WCH_FAULT = 3'b100,
        WCH_CHECK = 3'b101
    } wch_state_t;
endpackage

//--- src/wch_if.sv
// Discrete handshake lines between welder and machine controller.
`timescale 1ns/10ps
`default_nettype none
interface wch_if;
    logic start_a; // First paired start input.
    logic start_b; // Second paired start input.
    logic start_single; // Single start on a user input.
    logic reset_in; // External reset input.
    logic abort_in; // Cycle abort input.
    logic estop_in; // Emergency halt input, high while halted.
    logic ready_out; // Ready for a start.
    logic start_letgo_permit_out; // Start may be released.
    logic fault_alarm_out; // Fault alarm.
    logic stroke_clear_out; // Head past clearance distance.
    modport device (
        input start_a, start_b, start_single, reset_in, abort_in, estop_in,
        output ready_out, start_letgo_permit_out, fault_alarm_out,
        output stroke_clear_out
    );
    modport ctrl (
        output start_a, start_b, start_single, reset_in, abort_in, estop_in,
        input ready_out, start_letgo_permit_out, fault_alarm_out,
        input stroke_clear_out
    );
endinterface
`default_nettype wire

//--- src/wch_device.sv
// Welder end of the weld cycle handshake.
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "wch_params.svh"
module wch_device #(
    parameter int DEB_CYC = `WCH_DEB_CYC,
    parameter int WELD_CYC = `WCH_WELD_CYC,
    parameter int RETRACT_CYC = `WCH_RETRACT_CYC,
    parameter int CLEAR_CYC = `WCH_CLEAR_CYC,
    parameter int CHECK_CYC = `WCH_CHECK_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Handshake lines.
    wch_if.device link,
    // Local configuration and status.
    input wire logic solenoid_mode,
    input wire logic clear_enable,
    input wire logic panel_reset,
    input wire logic weld_fail,
    output logic [2:0] state_out
);
    localparam int NIN = 7;
    // Raw pin vector, two-flop synchroniser and debounced copy.
    logic [NIN-1:0] raw;
    logic [NIN-1:0] sync1_q;
    logic [NIN-1:0] sync2_q;
    logic [NIN-1:0] deb_q;
    logic [NIN-1:0] deb_prev_q;
    logic [7:0] deb_cnt_q [NIN];
    // State machine and timer.
    wch_pkg::wch_state_t state_q;
    logic [15:0] tmr_q;
    // Set when the fault came from an emergency halt.
    logic halted_q;
    // Output registers.
    logic ready_q;
    logic permit_q;
    logic fault_q;
    logic clear_q;
    // Named views of the clean inputs.
    logic start_ok;
    logic rst_edge;
    logic abort_c;
    logic estop_c;

    assign raw = {panel_reset, link.estop_in, link.abort_in,
                  link.reset_in, link.start_single, link.start_b,
                  link.start_a};

    // Two flip-flops before any logic reads a pin.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    // Each input changes only after standing stable for DEB_CYC cycles.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            deb_q <= '0;
            deb_prev_q <= '0;
            for (int i = 0; i < NIN; i++)
                deb_cnt_q[i] <= 8'h00;
        end
        else
        begin
            deb_prev_q <= deb_q;
            for (int i = 0; i < NIN; i++)
            begin
                if (sync2_q[i] == deb_q[i])
                    deb_cnt_q[i] <= 8'h00;
                else if (deb_cnt_q[i] == 8'(DEB_CYC - 1))
                begin
                    deb_q[i] <= sync2_q[i];
                    deb_cnt_q[i] <= 8'h00;
                end
                else
                    deb_cnt_q[i] <= deb_cnt_q[i] + 8'h01;
            end
        end
    end

    // Stack-only takes the single start; solenoid needs both paired ones.
    always_comb
    begin
        if (!solenoid_mode)
            start_ok = deb_q[2];
        else
            start_ok = deb_q[0] && deb_q[1];
    end

    // Rising edge of either reset source; a held level gives one edge.
    assign rst_edge = (deb_q[3] && !deb_prev_q[3])
                      || (deb_q[6] && !deb_prev_q[6]);
    assign abort_c = deb_q[4];
    assign estop_c = deb_q[5];

    // Cycle sequencer.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= wch_pkg::WCH_INIT;
            tmr_q <= 16'h0000;
            halted_q <= 1'b0;
        end
        else if (estop_c && state_q != wch_pkg::WCH_FAULT)
        begin
            // Halt wins everywhere; unit stays down until reset.
            state_q <= wch_pkg::WCH_FAULT;
            halted_q <= 1'b1;
            tmr_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                wch_pkg::WCH_INIT:
                begin
                    state_q <= wch_pkg::WCH_READY;
                end
                wch_pkg::WCH_READY:
                begin
                    // Only a ready unit begins a cycle.
                    if (start_ok && ready_q)
                    begin
                        state_q <= wch_pkg::WCH_WELD;
                        tmr_q <= 16'h0000;
                    end
                end
                wch_pkg::WCH_WELD:
                begin
                    if (weld_fail)
                        state_q <= wch_pkg::WCH_FAULT;
                    else if (abort_c || tmr_q == 16'(WELD_CYC - 1))
                    begin
                        // Abort retracts at once, no extra checking.
                        state_q <= wch_pkg::WCH_RETRACT;
                        tmr_q <= 16'h0000;
                    end
                    else
                        tmr_q <= tmr_q + 16'h0001;
                end
                wch_pkg::WCH_RETRACT:
                begin
                    if (tmr_q == 16'(RETRACT_CYC - 1))
                        state_q <= wch_pkg::WCH_READY;
                    else
                        tmr_q <= tmr_q + 16'h0001;
                end
                wch_pkg::WCH_FAULT:
                begin
                    // Reset counts only here, while the alarm shows.
                    if (rst_edge && fault_q && !estop_c)
                    begin
                        tmr_q <= 16'h0000;
                        if (halted_q)
                            state_q <= wch_pkg::WCH_CHECK;
                        else
                            state_q <= wch_pkg::WCH_READY;
                    end
                end
                wch_pkg::WCH_CHECK:
                begin
                    // Extra hardware check after an emergency halt.
                    if (tmr_q == 16'(CHECK_CYC - 1))
                    begin
                        state_q <= wch_pkg::WCH_READY;
                        halted_q <= 1'b0;
                    end
                    else
                        tmr_q <= tmr_q + 16'h0001;
                end
                default:
                begin
                    state_q <= wch_pkg::WCH_INIT;
                end
            endcase
        end
    end

    // Outputs follow the state one cycle later, straight from flops; ready also waits for start_ok to drop.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ready_q <= 1'b0;
            permit_q <= 1'b0;
            fault_q <= 1'b0;
        end
        else
        begin
            ready_q <= (state_q == wch_pkg::WCH_READY) && !start_ok
                       || (state_q == wch_pkg::WCH_READY && ready_q);
            permit_q <= (state_q == wch_pkg::WCH_WELD);
            fault_q <= (state_q == wch_pkg::WCH_FAULT);
        end
    end

    // Stroke clear rises partway through the retract, before ready.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            clear_q <= 1'b0;
        else
            clear_q <= clear_enable
                       && state_q == wch_pkg::WCH_RETRACT
                       && tmr_q >= 16'(CLEAR_CYC);
    end

    assign link.ready_out = ready_q;
    assign link.start_letgo_permit_out = permit_q;
    assign link.fault_alarm_out = fault_q;
    assign link.stroke_clear_out = clear_q;
    assign state_out = state_q;
endmodule
`default_nettype wire

//--- src/wch_ctrl.sv
// Machine controller end of the handshake, with an AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
`include "wch_params.svh"
module wch_ctrl (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt.
    output logic irq,
    // Handshake lines.
    wch_if.ctrl link
);
    // Synchronised copies of the welder outputs.
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] prev_q;
    // Registers.
    logic [4:0] ctrl_q;
    logic [`WCH_IRQ_W-1:0] irq_q;
    logic [`WCH_IRQ_W-1:0] mask_q;
    // Outputs to welder.
    logic start_q;
    logic reset_q;
    logic [3:0] rst_cnt_q; // Cycles left in the reset pulse.
    // Data phase capture.
    logic dp_wr_q;
    logic dp_rd_q;
    logic [7:0] dp_addr_q;
    logic [31:0] rd_word; // Word selected by the data phase address.
    logic irq_out_q;
    logic [3:0] rise;
    logic rd_irq;

    // Welder outputs come from another device, so two flops first.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            prev_q <= 4'h0;
        end
        else
        begin
            s1_q <= {link.ready_out, link.stroke_clear_out,
                     link.start_letgo_permit_out, link.fault_alarm_out};
            s2_q <= s1_q;
            prev_q <= s2_q;
        end
    end
    assign rise = s2_q & ~prev_q;

    // Address phase capture; reads answer with the data phase.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dp_wr_q <= 1'b0;
            dp_rd_q <= 1'b0;
            dp_addr_q <= 8'h00;
        end
        else if (hready)
        begin
            dp_wr_q <= hsel && htrans[1] && hwrite;
            dp_rd_q <= hsel && htrans[1] && !hwrite;
            dp_addr_q <= haddr;
        end
    end
    assign rd_irq = dp_rd_q && dp_addr_q == `WCH_IRQ_OFS;

    // Control and mask writes.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q <= 5'h00;
            mask_q <= '0;
        end
        else if (dp_wr_q)
        begin
            if (dp_addr_q == `WCH_CTRL_OFS)
                ctrl_q <= hwdata[4:0];
            if (dp_addr_q == `WCH_MASK_OFS)
                mask_q <= hwdata[`WCH_IRQ_W-1:0];
        end
    end

    // Sticky events; a read clears, but a new event in that cycle wins.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            irq_q <= '0;
        else
            irq_q <= (rd_irq ? '0 : irq_q) | rise;
    end

    // Read data, zero for unmapped words.
    always_comb
    begin
        case (dp_addr_q)
            `WCH_CTRL_OFS: rd_word = {27'h0, ctrl_q};
            `WCH_STAT_OFS: rd_word = {28'h0, s2_q};
            `WCH_IRQ_OFS: rd_word = {28'h0, irq_q};
            `WCH_MASK_OFS: rd_word = {28'h0, mask_q};
            default: rd_word = 32'h0;
        endcase
    end
    assign hrdata = dp_rd_q ? rd_word : 32'h0;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Start held until permit or alarm, then dropped at once.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            start_q <= 1'b0;
        else if (s2_q[1] || s2_q[0])
            start_q <= 1'b0;
        else if (ctrl_q[`WCH_CTRL_START] && s2_q[3])
            start_q <= 1'b1;
        else if (!ctrl_q[`WCH_CTRL_START])
            start_q <= 1'b0;
    end

    // One pulse of reset per alarm edge when automatic reset is on.
    // The welder debounces its inputs, so a one-cycle pulse would be
    // filtered away; the pulse is stretched, then dropped for a new edge.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reset_q <= 1'b0;
            rst_cnt_q <= 4'h0;
        end
        else if (ctrl_q[`WCH_CTRL_AUTORST] && rise[0])
        begin
            reset_q <= 1'b1;
            rst_cnt_q <= 4'(`WCH_RST_PULSE_CYC - 1);
        end
        else if (rst_cnt_q != 4'h0)
            rst_cnt_q <= rst_cnt_q - 4'h1;
        else
            reset_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            irq_out_q <= 1'b0;
        else
            irq_out_q <= |(irq_q & mask_q);
    end
    assign irq = irq_out_q;

    assign link.start_a = start_q && !ctrl_q[`WCH_CTRL_SINGLE];
    assign link.start_b = start_q && !ctrl_q[`WCH_CTRL_SINGLE];
    assign link.start_single = start_q && ctrl_q[`WCH_CTRL_SINGLE];
    assign link.reset_in = reset_q;
    assign link.abort_in = ctrl_q[`WCH_CTRL_ABORT];
    assign link.estop_in = ctrl_q[`WCH_CTRL_ESTOP];
endmodule
`default_nettype wire

//--- test/wch_sva.sv
// Assertions on the handshake lines between the two ends.
`timescale 1ns/10ps
`default_nettype none
module wch_sva (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Lines from the controller.
    input wire logic start_a,
    input wire logic start_b,
    input wire logic start_single,
    input wire logic reset_in,
    input wire logic abort_in,
    input wire logic estop_in,
    // Lines from the welder.
    input wire logic ready_out,
    input wire logic start_letgo_permit_out,
    input wire logic fault_alarm_out,
    input wire logic stroke_clear_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // The permit stands for seven cycles after its rise unless abort or fault cut it.
    sequence weld_run;
        (start_letgo_permit_out || abort_in || fault_alarm_out) [*7];
    endsequence
    // Ready comes back within a bounded wait.
    sequence back_ready;
        ##[1:200] ready_out;
    endsequence
    permit_idle_a: assert property (
        start_letgo_permit_out |-> !ready_out) else $error("permit with ready");
    start_ready_a: assert property (
        $rose(start_letgo_permit_out) |-> $past(ready_out))
        else $error("start while not ready");
    start_cause_a: assert property (
        $rose(start_letgo_permit_out) |->
        (start_a && start_b) || start_single) else $error("permit no start");
    permit_hold_a: assert property (
        $rose(start_letgo_permit_out) |=> weld_run) else $error("permit short");
    clear_first_a: assert property (
        $rose(stroke_clear_out) |-> !ready_out) else $error("clear late");
    fault_block_a: assert property (
        fault_alarm_out |-> !ready_out) else $error("ready in fault");
    fault_back_a: assert property (
        $fell(fault_alarm_out) |-> back_ready) else $error("no ready");
    reset_cause_a: assert property (
        $rose(reset_in) |-> fault_alarm_out) else $error("reset no fault");
    halt_fault_a: assert property (
        $rose(estop_in) |-> ##[1:20] fault_alarm_out) else $error("no halt");
    abort_fast_a: assert property (
        $rose(abort_in) && !ready_out |-> ##[1:40] ready_out)
        else $error("abort slow");
endmodule
`default_nettype wire

//--- test/weld_cycle_handshake_tb.sv
// Self-checking bench for both ends of the weld cycle handshake.
`timescale 1ns/10ps
`default_nettype none
`include "wch_params.svh"
`define WCH_CHK(nm, ex, got) \
    begin \
        comparisons++; \
        if ((got) !== (ex)) \
        begin \
            errors++; \
            $display("wrong value %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module weld_cycle_handshake_tb;
    logic clk, rstn, hsel, hwrite, hreadyout, hresp, irq;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, state_out;
    logic [31:0] hwdata, hrdata, rd;
    logic solenoid_mode, clear_enable, panel_reset, weld_fail;
    int errors, comparisons, pcnt, n, ccnt;
    // Shorthand for the welder outputs.
    wire logic rdy, pmt, flt, clr;
    wch_if wch_if_i ();
    assign rdy = wch_if_i.ready_out;
    assign pmt = wch_if_i.start_letgo_permit_out;
    assign flt = wch_if_i.fault_alarm_out;
    assign clr = wch_if_i.stroke_clear_out;
    wch_device wch_device_i (.clk(clk), .rstn(rstn), .link(wch_if_i),
        .solenoid_mode(solenoid_mode), .clear_enable(clear_enable),
        .panel_reset(panel_reset), .weld_fail(weld_fail),
        .state_out(state_out));
    wch_ctrl wch_ctrl_i (.clk(clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(wch_if_i));
    wch_sva wch_sva_i (.clk(clk), .rstn(rstn),
        .start_a(wch_if_i.start_a), .start_b(wch_if_i.start_b),
        .start_single(wch_if_i.start_single),
        .reset_in(wch_if_i.reset_in), .abort_in(wch_if_i.abort_in),
        .estop_in(wch_if_i.estop_in), .ready_out(rdy),
        .start_letgo_permit_out(pmt), .fault_alarm_out(flt),
        .stroke_clear_out(clr));
    // Clock of 25 ns.
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Counts cycles with the permit up, to spot cycles that never should be.
    always @(posedge clk) if (pmt === 1'b1) pcnt++;
    // Counts cycles with stroke clear up, to spot it while disabled.
    always @(posedge clk) if (clr === 1'b1) ccnt++;
    // One single word transfer; read data is taken at the edge that
    // ends the data phase.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        hsize <= 3'b010;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do
        begin
            @(posedge clk);
            rd = hrdata;
        end
        while (hreadyout !== 1'b1);
        `WCH_CHK("hresp", 1'b0, hresp)
    endtask
    // Waits a bounded time for a welder output to reach a level.
    task automatic wt(input int sel, input logic v, input int lim);
        logic s;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            s = sel == 0 ? rdy : sel == 1 ? pmt : sel == 2 ? flt : clr;
        end
        while (s !== v && n < lim);
        `WCH_CHK("link output", v, s)
    endtask
    // Idle state, unmapped place and mask read back.
    task automatic t_idle;
        wt(0, 1'b1, 40);
        `WCH_CHK("state", 3'h1, state_out)
        bus(1'b0, 8'h10, 32'h0);
        `WCH_CHK("unmapped", 32'h0, rd)
        bus(1'b1, `WCH_MASK_OFS, 32'hf);
        bus(1'b0, `WCH_MASK_OFS, 32'h0);
        `WCH_CHK("mask", 32'hf, rd)
        bus(1'b0, `WCH_IRQ_OFS, 32'h0);
    endtask
    // Paired start, release on permit, clear before ready, interrupts.
    task automatic t_weld;
        bus(1'b1, `WCH_CTRL_OFS, 32'h1);
        wt(1, 1'b1, 40);
        `WCH_CHK("ready in weld", 1'b0, rdy)
        bus(1'b1, `WCH_CTRL_OFS, 32'h0);
        wt(3, 1'b1, 80);
        `WCH_CHK("ready at clear", 1'b0, rdy)
        wt(0, 1'b1, 40);
        // Let the ready event pass the synchroniser before reading status.
        repeat (4) @(posedge clk);
        `WCH_CHK("irq", 1'b1, irq)
        bus(1'b0, `WCH_IRQ_OFS, 32'h0);
        `WCH_CHK("irq status", 32'he, rd)
        bus(1'b0, `WCH_IRQ_OFS, 32'h0);
        `WCH_CHK("irq cleared", 32'h0, rd)
        @(posedge clk);
        `WCH_CHK("irq low", 1'b0, irq)
    endtask
    // Single start refused with solenoids, accepted for a bare stack.
    task automatic t_single;
        int c0;
        n = pcnt;
        bus(1'b1, `WCH_CTRL_OFS, 32'h11);
        repeat (40) @(posedge clk);
        `WCH_CHK("single refused", n, pcnt)
        bus(1'b1, `WCH_CTRL_OFS, 32'h0);
        // Let the dropped start clear the debouncer before the mode changes.
        repeat (10) @(posedge clk);
        solenoid_mode <= 1'b0;
        clear_enable <= 1'b0;
        c0 = ccnt;
        bus(1'b1, `WCH_CTRL_OFS, 32'h11);
        wt(1, 1'b1, 40);
        bus(1'b1, `WCH_CTRL_OFS, 32'h0);
        wt(0, 1'b1, 80);
        `WCH_CHK("clear disabled", c0, ccnt)
        solenoid_mode <= 1'b1;
        clear_enable <= 1'b1;
    endtask
    // Reset outside a fault, held reset, then a fresh reset edge.
    task automatic t_fault;
        panel_reset <= 1'b1;
        repeat (20) @(posedge clk);
        `WCH_CHK("reset no fault", 3'h1, state_out)
        weld_fail <= 1'b1;
        bus(1'b1, `WCH_CTRL_OFS, 32'h1);
        wt(2, 1'b1, 80);
        n = pcnt;
        repeat (30) @(posedge clk);
        `WCH_CHK("start in fault", n, pcnt)
        bus(1'b1, `WCH_CTRL_OFS, 32'h0);
        weld_fail <= 1'b0;
        repeat (30) @(posedge clk);
        `WCH_CHK("held reset", 1'b1, flt)
        panel_reset <= 1'b0;
        repeat (10) @(posedge clk);
        panel_reset <= 1'b1;
        wt(2, 1'b0, 40);
        wt(0, 1'b1, 40);
        panel_reset <= 1'b0;
    endtask
    // Halt needs a reset and takes the long check; abort does not.
    task automatic t_halt;
        bus(1'b1, `WCH_CTRL_OFS, 32'h4);
        wt(2, 1'b1, 40);
        bus(1'b1, `WCH_CTRL_OFS, 32'h0);
        repeat (100) @(posedge clk);
        `WCH_CHK("halt kept", 1'b0, rdy)
        panel_reset <= 1'b1;
        wt(0, 1'b1, 300);
        `WCH_CHK("check time", 1'b1, n >= `WCH_CHECK_CYC)
        panel_reset <= 1'b0;
        bus(1'b1, `WCH_CTRL_OFS, 32'h1);
        wt(1, 1'b1, 40);
        bus(1'b1, `WCH_CTRL_OFS, 32'h2);
        // Abort must cut the permit short of a full weld time.
        wt(1, 1'b0, 20);
        `WCH_CHK("abort cuts weld", 1'b1, n < `WCH_WELD_CYC - 4)
        wt(0, 1'b1, 60);
        `WCH_CHK("abort quick", 1'b1, n < `WCH_CHECK_CYC)
        `WCH_CHK("abort no fault", 1'b0, flt)
        bus(1'b1, `WCH_CTRL_OFS, 32'h0);
    endtask
    // Controller pulses reset on alarm by itself; fault interrupt masked.
    task automatic t_auto;
        bus(1'b1, `WCH_MASK_OFS, 32'h0);
        bus(1'b0, `WCH_IRQ_OFS, 32'h0);
        weld_fail <= 1'b1;
        bus(1'b1, `WCH_CTRL_OFS, 32'h9);
        wt(2, 1'b1, 80);
        `WCH_CHK("masked irq", 1'b0, irq)
        bus(1'b1, `WCH_CTRL_OFS, 32'h8);
        weld_fail <= 1'b0;
        wt(2, 1'b0, 60);
        wt(0, 1'b1, 60);
        bus(1'b0, `WCH_IRQ_OFS, 32'h0);
        `WCH_CHK("fault bit", 1'b1, rd[`WCH_IRQ_FAULT])
        bus(1'b1, `WCH_CTRL_OFS, 32'h0);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        {rstn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {panel_reset, weld_fail} = 2'b00;
        {solenoid_mode, clear_enable} = 2'b11;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_idle();
        t_weld();
        t_single();
        t_fault();
        t_halt();
        t_auto();
        final_report();
    end
    // Watchdog against a hang.
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end
endmodule
`default_nettype wire
